// *** sim/host_model.sv ***
// Serial master model: frames, clocks and data for the converter's host link
`timescale 1ns/1ps
module host_model (
    output logic        sync_n,    // Frame sync, active low
    output logic        sclk,      // Serial clock, runs only inside frames
    output logic        din,       // Data toward the device
    input  wire logic   dout,      // Device output level
    input  wire logic   dout_oe,   // Device drives dout while high
    output logic [15:0] rx_word,   // Last readback word captured
    output logic        rx_done    // Pulse when rx_word is fresh
);
    logic last_drv;                // Last level seen on a driven output

    initial begin
        sync_n   = 1'b1;
        sclk     = 1'b0;
        din      = 1'b0;
        rx_word  = 16'h0000;
        rx_done  = 1'b0;
        last_drv = 1'b0;
    end

    // One frame of n clocks, bits sent from bits[n-1] down
    task automatic xfer(input int n, input logic [23:0] bits, input logic rd);
        logic [15:0] rx;
        rx = 16'h0000;
        #37 sync_n = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            din  = bits[i];
            // Capture just ahead of the fall, where the device's bit is valid
            #95;
            // A released line does not hold its level, so read the inverse
            rx = {rx[14:0], dout_oe ? dout : ~last_drv};
            if (dout_oe) begin
                last_drv = dout;
            end
            #5 sclk = 1'b0;
            #100;
        end
        #100 sync_n = 1'b1;
        if (rd) begin
            rx_word = rx;
            rx_done = 1'b1;
            #1 rx_done = 1'b0;
        end
        #200;
    endtask
endmodule // host_model

// *** sim/tb.sv ***
// Self-checking bench for the converter's serial host link
`timescale 1ns/1ps
`include "dac_link_cfg.svh"
module tb;
    logic        clk, srst, track_hold_mode;
    logic [13:0] rd_data;
    wire         sync_n, sclk, din, dout, dout_oe, wr_valid, wr_track_hold, wr_cal, wr_offset_sel, wr_test, rb_offset;
    wire [1:0]   wr_mode;
    wire [4:0]   channel_address, rb_channel;
    wire [13:0]  wr_data;
    wire [15:0]  rx_word;
    wire         rx_done;
    int          failures, cmp_count, seed;
    logic [24:0] wq[$];            // Expected write results
    logic [15:0] rq[$];            // Expected readback words
    logic [23:0] f;
    logic [4:0]  off_pad;

    dac_serial_host_link dac_serial_host_link_i (.clk(clk), .srst(srst), .sync_n_pin(sync_n), .sclk_pin(sclk),
        .din_pin(din), .track_hold_mode(track_hold_mode), .rd_data(rd_data), .dout(dout), .dout_oe(dout_oe),
        .wr_valid(wr_valid), .wr_track_hold(wr_track_hold), .wr_mode(wr_mode), .wr_cal(wr_cal),
        .wr_offset_sel(wr_offset_sel), .wr_test(wr_test), .channel_address(channel_address), .wr_data(wr_data),
        .rb_offset(rb_offset), .rb_channel(rb_channel));
    host_model host_model_i (.sync_n(sync_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
        .rx_word(rx_word), .rx_done(rx_done));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Fields the device should decode from a frame; address is zero when offset chosen
    function automatic logic [24:0] exp_of(input logic th, input logic [23:0] v);
        logic [9:0] h;
        h = th ? v[9:0] : v[23:14];
        return {th, h[9:5], h[6] ? 5'h00 : h[4:0], th ? 14'h0000 : v[13:0]};
    endfunction

    // Send one write frame of n clocks and wait for its result to be taken
    task automatic wr(input logic th, input logic [23:0] v, input int n, input logic [23:0] bits);
        @(posedge clk) #2 track_hold_mode = th;
        wq.push_back(exp_of(th, v));
        host_model_i.xfer(n, bits, 1'b0);
        repeat (40) if (wq.size() != 0) @(posedge clk);
    endtask

    // Write monitor: every completion matches the oldest note
    always @(posedge clk) begin
        if (wr_valid === 1'b1) begin
            if (wq.size() == 0) begin
                check("spurious wr_valid", 1, 0);
            end else begin
                check("write fields", {wr_track_hold, wr_mode, wr_cal, wr_offset_sel, wr_test, channel_address,
                      wr_data}, wq.pop_front());
            end
        end
    end

    // Readback monitor
    always @(posedge rx_done) begin
        if (rq.size() == 0) begin
            check("spurious readback", 1, 0);
        end else begin
            check("readback word", rx_word, rq.pop_front());
        end
    end

    initial begin
        seed = 32'h4544;
        srst = 1'b1;
        track_hold_mode = 1'b0;
        rd_data = 14'h0000;
        repeat (4) @(posedge clk);
        #2 srst = 1'b0;
        check("dout_oe after reset", dout_oe, 0);
        // Converter-mode frames, every plain mode code, offset on and off
        for (int k = 0; k < 6; k++) begin
            f = 24'($random(seed));
            f[23:22] = (k % 3 == 0) ? 2'h0 : (k % 3 == 1) ? 2'h2 : 2'h3;
            f[20] = k[0];
            wr(1'b0, f, 24, f);
        end
        // Ten-bit frames sent as two bytes, left-justified; the six extra clocks are ignored
        for (int k = 0; k < 4; k++) begin
            f = 24'($random(seed));
            f[9:8] = (k % 2 == 0) ? 2'h0 : 2'h3;
            f[6] = k[1];
            off_pad = 5'($random(seed));
            wr(1'b1, {14'h0000, f[9:0]}, 16, {8'h00, f[9:0], off_pad, 1'b1});
        end
        // Arm a readback, then read it with the strap either way
        for (int k = 0; k < 4; k++) begin
            f = 24'($random(seed));
            f[23:22] = `MODE_READBACK;
            f[20] = k[0];
            wr(1'b0, f, 24, f);
            check("rb_offset", rb_offset, f[20]);
            check("rb_channel", rb_channel, f[20] ? 5'h00 : f[18:14]);
            @(posedge clk) #2 track_hold_mode = k[1];
            rd_data = 14'($random(seed));
            rq.push_back({1'b0, rd_data, ~rd_data[0]});
            host_model_i.xfer(16, 24'($random(seed)), 1'b1);
            repeat (8) @(posedge clk);
            check("dout_oe idle", dout_oe, 0);
        end
        check("pending notes", wq.size() + rq.size(), 0);
        final_report();
    end

    // Watchdog well beyond the expected run of about 85 us
    initial begin
        #2000000;
        failures++;
        final_report();
    end
endmodule // tb

// *** verilog/dac_link_cfg.svh ***
// Constants for the serial host link: frame lengths, field positions, mode codes
`ifndef DAC_LINK_CFG_SVH
`define DAC_LINK_CFG_SVH

// Frame lengths in serial clocks
`define TH_BITS      5'h0A
`define CV_BITS      5'h18
`define RB_CLKS      5'h10
// Falling edge count at which the readback output is released
`define RB_OE_OFF    5'h0F

// Converter-mode frame field positions
`define CV_HDR_MSB   23
`define CV_HDR_LSB   14
`define CV_DATA_MSB  13

// Mode code that arms a readback frame
`define MODE_READBACK 2'h1

// Number of synchronised pins
`define PIN_COUNT    4

`endif

// *** verilog/dac_link_pkg.sv ***
// Types shared by the serial host link modules
package dac_link_pkg;

    // Frame state, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WRITE = 4'h2,
        ST_READ  = 4'h4,
        ST_DONE  = 4'h8
    } link_state_e;

    // Ten-bit command header, first bit sent is mode[1]
    typedef struct packed {
        logic [1:0] mode;
        logic       cal;
        logic       offset_sel;
        logic       test;
        logic [4:0] channel_address;
    } hdr_s;

endpackage

// *** verilog/dac_serial_host_link.sv ***
// Device-side serial port of a 32-channel converter: frame decode, write capture, readback shift-out
//
// What this block does
// - Sample input bits on serial clock falls.
// - Update serial output on serial clock rises.
// - Readback frame spans sixteen serial clocks.
// - Fourteen result bits centred, one pad each side.
// - Track/hold write frame is ten bits.
// - Converter write frame is twenty-four bits.
// - Most significant bit first both ways.
// - Sync fall clears counter; extra edges ignored.
// - Output drives from first rise, releases at the fifteenth fall.
// - Five-bit address; offset select overrides it.
`timescale 1ns/1ps
module dac_serial_host_link
    import dac_link_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         sync_n_pin,       // Frame sync pin, active low
    input  wire logic         sclk_pin,         // Serial clock pin from host
    input  wire logic         din_pin,          // Serial data in pin
    input  wire logic         track_hold_mode,  // Mode strap pin: high selects ten-bit frames
    input  wire logic [13:0]  rd_data,          // Contents of the channel named by rb_channel
    output logic              dout,             // Serial data out level
    output logic              dout_oe,          // High while the output pin is driven
    output logic              wr_valid,         // One-cycle pulse: a write frame completed
    output logic              wr_track_hold,    // Completed frame was ten-bit
    output logic [1:0]        wr_mode,          // Mode bits of the frame
    output logic              wr_cal,           // Calibration bit
    output logic              wr_offset_sel,    // Offset channel chosen
    output logic              wr_test,          // Test bit
    output logic [4:0]        channel_address,  // Selected channel, zero when offset chosen
    output logic [13:0]       wr_data,          // Converter word, zero for ten-bit frames
    output logic              rb_offset,        // Readback targets the offset channel
    output logic [4:0]        rb_channel        // Channel that the next readback returns
);
`include "dac_link_cfg.svh"

    pin_sync_if ps ();                  // Synchronised pins and edges

    // Pin stage: every pin passes two flops before use
    pin_sync u_pin_sync (
        .clk            (clk),
        .srst           (srst),
        .sync_n_pin     (sync_n_pin),
        .sclk_pin       (sclk_pin),
        .din_pin        (din_pin),
        .track_hold_pin (track_hold_mode),
        .ps             (ps)
    );

    // Header view of a ten-bit slice, used for both frame widths
    function automatic hdr_s hdr_of(input logic [9:0] bits);
        hdr_of = hdr_s'(bits);
    endfunction

    link_state_e state_q, state_d;      // Frame state
    logic [4:0]  cnt_q, cnt_d;          // Serial clocks seen in this frame
    logic        th_q, th_d;            // Frame width latched at sync fall
    logic [23:0] sh_q, sh_d;            // Input shift register
    logic [15:0] rsh_q, rsh_d;          // Readback shift register with pads
    logic        dout_q, dout_d;
    logic        oe_q, oe_d;
    logic        armed_q, armed_d;      // Next frame is a readback
    logic        wv_q, wv_d;
    logic        wth_q, wth_d;
    hdr_s        hdr_q, hdr_d;          // Decoded header of last write
    logic [13:0] wdat_q, wdat_d;
    logic        rbo_q, rbo_d;
    logic [4:0]  rbc_q, rbc_d;
    hdr_s        hdr_n;                 // Header of the frame now closing
    logic [23:0] sh_n;                  // Shift register after this bit

    // Next-state logic for frame control, capture and shift-out
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        th_d    = th_q;
        sh_d    = sh_q;
        rsh_d   = rsh_q;
        dout_d  = dout_q;
        oe_d    = oe_q;
        armed_d = armed_q;
        wv_d    = 1'b0;
        wth_d   = wth_q;
        hdr_d   = hdr_q;
        wdat_d  = wdat_q;
        rbo_d   = rbo_q;
        rbc_d   = rbc_q;
        sh_n    = {sh_q[22:0], ps.din_s};
        hdr_n   = th_q ? hdr_of(sh_n[9:0]) : hdr_of(sh_n[`CV_HDR_MSB:`CV_HDR_LSB]);
        case (state_q)
            // Waiting for a frame; only a sync fall starts one
            ST_IDLE, ST_DONE: begin
                if (ps.sync_fall) begin
                    cnt_d = 5'h00;
                    th_d  = ps.track_hold_s;
                    if (armed_q) begin
                        // Snapshot the result so a changing channel cannot tear it
                        state_d = ST_READ;
                        rsh_d   = {1'b0, rd_data, 1'b0};
                        armed_d = 1'b0;
                    end else begin
                        state_d = ST_WRITE;
                    end
                end
            end
            // Shift in on falls; further sync edges are ignored here
            ST_WRITE: begin
                if (ps.sclk_fall) begin
                    sh_d  = sh_n;
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == (th_q ? `TH_BITS : `CV_BITS) - 5'h01) begin
                        state_d = ST_DONE;
                        wv_d    = 1'b1;
                        wth_d   = th_q;
                        hdr_d   = hdr_n;
                        wdat_d  = th_q ? 14'h0000 : sh_n[`CV_DATA_MSB:0];
                        if (hdr_n.offset_sel) begin
                            hdr_d.channel_address = 5'h00;
                        end
                        if (hdr_n.mode == `MODE_READBACK) begin
                            armed_d = 1'b1;
                            rbo_d   = hdr_n.offset_sel;
                            rbc_d   = hdr_n.offset_sel ? 5'h00 : hdr_n.channel_address;
                        end
                    end
                end
            end
            // Shift out on rises; input data is ignored
            ST_READ: begin
                if (ps.sclk_rise) begin
                    dout_d = rsh_q[15];
                    rsh_d  = {rsh_q[14:0], 1'b0};
                    cnt_d  = cnt_q + 5'h01;
                    if (cnt_q == 5'h00) begin
                        oe_d = 1'b1;
                    end
                    if (cnt_q == `RB_CLKS - 5'h01) begin
                        state_d = ST_DONE;
                    end
                end else if (ps.sclk_fall && cnt_q == `RB_OE_OFF) begin
                    oe_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (srst) begin
            state_d = ST_IDLE;
            cnt_d   = 5'h00;
            th_d    = 1'b0;
            sh_d    = 24'h000000;
            rsh_d   = 16'h0000;
            dout_d  = 1'b0;
            oe_d    = 1'b0;
            armed_d = 1'b0;
            wth_d   = 1'b0;
            hdr_d   = '0;
            wdat_d  = 14'h0000;
            rbo_d   = 1'b0;
            rbc_d   = 5'h00;
        end
    end

    // Register the frame state
    always_ff @(posedge clk) begin
        state_q <= state_d;
        cnt_q   <= cnt_d;
        th_q    <= th_d;
        sh_q    <= sh_d;
        rsh_q   <= rsh_d;
        dout_q  <= dout_d;
        oe_q    <= oe_d;
        armed_q <= armed_d;
        wv_q    <= wv_d;
        wth_q   <= wth_d;
        hdr_q   <= hdr_d;
        wdat_q  <= wdat_d;
        rbo_q   <= rbo_d;
        rbc_q   <= rbc_d;
    end

    assign dout            = dout_q;
    assign dout_oe         = oe_q;
    assign wr_valid        = wv_q;
    assign wr_track_hold   = wth_q;
    assign wr_mode         = hdr_q.mode;
    assign wr_cal          = hdr_q.cal;
    assign wr_offset_sel   = hdr_q.offset_sel;
    assign wr_test         = hdr_q.test;
    assign channel_address = hdr_q.channel_address;
    assign wr_data         = wdat_q;
    assign rb_offset       = rbo_q;
    assign rb_channel      = rbc_q;

    // Checks on the link behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_sample_fall;
        state_q == ST_WRITE && ps.sclk_fall |=> sh_q[0] == $past(ps.din_s);
    endproperty
    a_sample_fall: assert property (p_sample_fall) else $error("input bit not taken on fall");

    property p_dout_on_rise;
        !$past(srst) && $changed(dout_q) |-> $past(ps.sclk_rise);
    endproperty
    a_dout_on_rise: assert property (p_dout_on_rise) else $error("output changed off a rise");

    property p_read_len;
        state_q == ST_READ && ps.sclk_rise && cnt_q == 5'h0F |=> state_q == ST_DONE && cnt_q == 5'h10;
    endproperty
    a_read_len: assert property (p_read_len) else $error("readback not ended at sixteen");

    property p_pad_first;
        state_q == ST_READ && ps.sclk_rise && cnt_q == 5'h00 |=> !dout_q && dout_oe;
    endproperty
    a_pad_first: assert property (p_pad_first) else $error("first readback slot not a driven pad");

    property p_th_len;
        state_q == ST_WRITE && th_q && ps.sclk_fall && cnt_q == 5'h09 |=> wr_valid && wr_track_hold;
    endproperty
    a_th_len: assert property (p_th_len) else $error("ten-bit frame not closed");

    property p_cv_len;
        state_q == ST_WRITE && !th_q && ps.sclk_fall && cnt_q == 5'h17 |=> wr_valid ##1 !wr_valid;
    endproperty
    a_cv_len: assert property (p_cv_len) else $error("converter frame not closed");

    property p_clear;
        (state_q == ST_IDLE || state_q == ST_DONE) && ps.sync_fall |=> cnt_q == 5'h00 && state_q != ST_DONE;
    endproperty
    a_clear: assert property (p_clear) else $error("sync fall did not start a frame");

    property p_ignore;
        state_q == ST_DONE && !ps.sync_fall |=> $stable(cnt_q) && state_q == ST_DONE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("clock not ignored after frame");

    property p_oe_off;
        state_q == ST_READ && ps.sclk_fall && cnt_q == 5'h0F |=> !dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output not released");

    property p_offset;
        wr_valid && wr_offset_sel |-> channel_address == 5'h00;
    endproperty
    a_offset: assert property (p_offset) else $error("address not overridden by offset select");

    c_th_write: cover property (wr_valid && wr_track_hold);
    c_cv_write: cover property (wr_valid && !wr_track_hold && wr_mode == `MODE_READBACK);
    c_readback: cover property (state_q == ST_READ ##1 state_q == ST_DONE);

endmodule // dac_serial_host_link

// *** verilog/pin_sync.sv ***
// Two-flop synchronisers and edge detectors for the serial link pins
`timescale 1ns/1ps
module pin_sync
    import dac_link_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         sync_n_pin,
    input  wire logic         sclk_pin,
    input  wire logic         din_pin,
    input  wire logic         track_hold_pin,
    pin_sync_if.producer      ps
);
`include "dac_link_cfg.svh"

    logic [`PIN_COUNT-1:0] raw;      // Pins as they arrive
    logic [`PIN_COUNT-1:0] meta_q;   // First stage, read only by the second
    logic [`PIN_COUNT-1:0] stab_q;   // Second stage, safe to use
    logic [`PIN_COUNT-1:0] prev_q;   // Delayed copy for edge finding
    logic [`PIN_COUNT-1:0] meta_d;
    logic [`PIN_COUNT-1:0] stab_d;
    logic [`PIN_COUNT-1:0] prev_d;

    assign raw = {track_hold_pin, din_pin, sclk_pin, sync_n_pin};

    // Next values of each pin's three stages; idle levels are high for sync and low otherwise
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
            always_comb begin
                meta_d[g] = srst ? (g == 0) : raw[g];
                stab_d[g] = srst ? (g == 0) : meta_q[g];
                prev_d[g] = srst ? (g == 0) : stab_q[g];
            end
        end
    endgenerate

    // Register all stages
    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        stab_q <= stab_d;
        prev_q <= prev_d;
    end

    // Edge pulses compare the second and third stages only
    assign ps.sync_fall    = prev_q[0] & ~stab_q[0];
    assign ps.sclk_rise    = ~prev_q[1] & stab_q[1];
    assign ps.sclk_fall    = prev_q[1] & ~stab_q[1];
    assign ps.din_s        = stab_q[2];
    assign ps.track_hold_s = stab_q[3];

endmodule // pin_sync

// *** verilog/pin_sync_if.sv ***
// Synchronised pin levels and edge pulses passed from the pin stage to the link logic
`timescale 1ns/1ps
interface pin_sync_if;
    logic sync_fall;        // One-cycle pulse on frame sync falling edge
    logic sclk_rise;        // One-cycle pulse on serial clock rising edge
    logic sclk_fall;        // One-cycle pulse on serial clock falling edge
    logic din_s;            // Synchronised serial data in
    logic track_hold_s;     // Synchronised track/hold mode strap

    modport producer (output sync_fall, sclk_rise, sclk_fall, din_s, track_hold_s);
    modport consumer (input  sync_fall, sclk_rise, sclk_fall, din_s, track_hold_s);
endinterface
